// ==== logic/gpio_port_indirect_config.sv ====
/*
 One GPIO port: AHB-Lite register slave with selector and data window reaching eight
 configuration sub-registers, output and input data registers, and the pin driver.
 Assumes one AHB-Lite master issuing single word transfers; pins synchronous to clk.
 Each port is a separate instance, so ports never share configuration state.
*/
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
module gpio_port_indirect_config #(
    parameter int WIDTH = gpio_cfg_pkg::PORT_WIDTH,
    parameter logic [7:0] ALT_EN_RESET = gpio_cfg_pkg::ALT_EN_RESET_ABC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    // Alternate function candidates, four per pin
    input wire logic [gpio_cfg_pkg::ALT_COUNT-1:0][WIDTH-1:0] alt_out,
    input wire logic [gpio_cfg_pkg::ALT_COUNT-1:0][WIDTH-1:0] alt_oe,
    // Pad controls
    output logic [WIDTH-1:0] open_drain,
    output logic [WIDTH-1:0] high_drive,
    output logic [WIDTH-1:0] stop_wake_en,
    output logic [WIDTH-1:0] pullup_en,
    // Sampled pin levels for peripherals
    output logic [WIDTH-1:0] port_input_value
);

    // Refuse widths the 8-bit register layout cannot hold
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("WIDTH must be 1 to 8");
    end

    gpio_cfg_pkg::bus_state_t st_q;
    logic write_q;
    logic mapped_q;
    logic [11:0] idx_q;
    logic [7:0] sel_q;
    logic [WIDTH-1:0] output_q;
    logic [WIDTH-1:0] sub_q [1:gpio_cfg_pkg::SUBREG_COUNT];
    logic [WIDTH-1:0] win_view;
    logic [31:0] rd_d;
    logic sel_ok;
    logic taken;
    logic data_end;
    logic wr_sel;
    logic wr_win;
    logic wr_out;

    pin_ctl_if #(.WIDTH(WIDTH)) cfg ();

    // A transfer is taken only while idle, so the wait state is never overlapped
    assign taken = ce && st_q == gpio_cfg_pkg::BUS_IDLE && hsel && htrans[1] && hready;
    assign data_end = ce && st_q == gpio_cfg_pkg::BUS_DATA;

    // Codes 01H..08H reach a sub-register; zero and the rest reach none
    assign sel_ok = sel_q >= gpio_cfg_pkg::SEL_DIRECTION && sel_q <= gpio_cfg_pkg::SEL_ALT_TWO;
    assign win_view = sel_ok ? sub_q[sel_q[3:0]] : '0;

    // Write strobes at the end of the data phase, when hwdata stands
    assign wr_sel = data_end && write_q && mapped_q && idx_q == gpio_cfg_pkg::IDX_SELECTOR;
    assign wr_win = data_end && write_q && mapped_q && idx_q == gpio_cfg_pkg::IDX_WINDOW && sel_ok;
    assign wr_out = data_end && write_q && mapped_q && idx_q == gpio_cfg_pkg::IDX_OUTPUT;

    // Bus state: one wait state per transfer keeps hrdata straight from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= gpio_cfg_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
        end else if (taken) begin
            st_q <= gpio_cfg_pkg::BUS_DATA;
            hreadyout <= 1'b0;
        end else if (data_end) begin
            st_q <= gpio_cfg_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
        end
    end

    // Address phase capture; only aligned whole-word transfers are mapped, others read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            write_q <= 1'b0;
            mapped_q <= 1'b0;
            idx_q <= 12'h000;
        end else if (taken) begin
            write_q <= hwrite;
            mapped_q <= haddr[31:14] == 18'h00000 && haddr[1:0] == 2'h0 && hsize == 3'h2;
            idx_q <= haddr[13:2];
        end
    end

    // Responses are always OKAY; unmapped reads give zero and writes are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            hresp <= 1'b0;
        end else if (ce) begin
            hresp <= 1'b0;
        end
    end

    // Read multiplexer over the four port registers
    always_comb begin
        rd_d = '0;
        if (mapped_q) begin
            unique case (idx_q)
                gpio_cfg_pkg::IDX_SELECTOR: rd_d[7:0] = sel_q;
                gpio_cfg_pkg::IDX_WINDOW: rd_d[WIDTH-1:0] = win_view;
                gpio_cfg_pkg::IDX_INPUT: rd_d[WIDTH-1:0] = port_input_value;
                gpio_cfg_pkg::IDX_OUTPUT: rd_d[WIDTH-1:0] = output_q;
                default: rd_d = '0;
            endcase
        end
    end

    // Read data register, loaded as the data phase ends
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= '0;
        end else if (data_end && !write_q) begin
            hrdata <= rd_d;
        end
    end

    // Selector register
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q <= gpio_cfg_pkg::SELECTOR_RESET;
        end else if (wr_sel) begin
            sel_q <= hwdata[7:0];
        end
    end

    // Output data register
    always_ff @(posedge clk) begin
        if (rst) begin
            output_q <= gpio_cfg_pkg::OUTPUT_RESET[WIDTH-1:0];
        end else if (wr_out) begin
            output_q <= hwdata[WIDTH-1:0];
        end
    end

    // Sub-registers behind the window; only the selected one takes a write
    for (genvar k = 1; k <= gpio_cfg_pkg::SUBREG_COUNT; k++) begin : g_sub
        localparam logic [WIDTH-1:0] RV =
            (k == gpio_cfg_pkg::SEL_DIRECTION) ? gpio_cfg_pkg::DIRECTION_RESET[WIDTH-1:0] :
            (k == gpio_cfg_pkg::SEL_ALT_ENABLE) ? ALT_EN_RESET[WIDTH-1:0] :
            gpio_cfg_pkg::SUBREG_RESET[WIDTH-1:0];
        always_ff @(posedge clk) begin
            if (rst) begin
                sub_q[k] <= RV;
            end else if (wr_win && sel_q[3:0] == 4'(k)) begin
                sub_q[k] <= hwdata[WIDTH-1:0];
            end
        end
    end

    // Configuration to the pin driver
    assign cfg.direction = sub_q[gpio_cfg_pkg::SEL_DIRECTION];
    assign cfg.alt_enable = sub_q[gpio_cfg_pkg::SEL_ALT_ENABLE];
    assign cfg.alt_one = sub_q[gpio_cfg_pkg::SEL_ALT_ONE];
    assign cfg.alt_two = sub_q[gpio_cfg_pkg::SEL_ALT_TWO];
    assign cfg.out_value = output_q;
    assign cfg.open_drain = sub_q[gpio_cfg_pkg::SEL_OPEN_DRAIN];

    // Pad controls come straight from their sub-register flops
    assign open_drain = sub_q[gpio_cfg_pkg::SEL_OPEN_DRAIN];
    assign high_drive = sub_q[gpio_cfg_pkg::SEL_HIGH_DRIVE];
    assign stop_wake_en = sub_q[gpio_cfg_pkg::SEL_STOP_WAKE];
    assign pullup_en = sub_q[gpio_cfg_pkg::SEL_PULLUP];

    // Pin multiplexing and sampling; alternates with nothing assigned are undefined
    pin_driver #(.WIDTH(WIDTH)) u_pins (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .cfg(cfg.pins),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .alt_out(alt_out),
        .alt_oe(alt_oe),
        .in_value(port_input_value)
    );

    // Steps of a transfer, reused by the checks below
    sequence s_taken;
        ce && st_q == gpio_cfg_pkg::BUS_IDLE && hsel && htrans[1] && hready;
    endsequence

    sequence s_win_write;
        data_end && write_q && mapped_q && idx_q == gpio_cfg_pkg::IDX_WINDOW;
    endsequence

    sequence s_win_read;
        data_end && !write_q && mapped_q && idx_q == gpio_cfg_pkg::IDX_WINDOW;
    endsequence

    property p_wait_state;
        @(posedge clk) disable iff (rst)
        s_taken |=> !hreadyout && st_q == gpio_cfg_pkg::BUS_DATA;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("no wait state after address phase");

    property p_answer;
        @(posedge clk) disable iff (rst)
        s_taken ##1 ce |=> hreadyout && !hresp;
    endproperty
    a_answer: assert property (p_answer) else $error("transfer not completed after one wait");

    property p_selector_reset;
        @(posedge clk)
        rst |=> sel_q == gpio_cfg_pkg::SELECTOR_RESET && hreadyout;
    endproperty
    a_selector_reset: assert property (p_selector_reset) else $error("selector not zero after reset");

    property p_direction_reset;
        @(posedge clk)
        rst |=> cfg.direction == gpio_cfg_pkg::DIRECTION_RESET[WIDTH-1:0] && pin_oe == '0;
    endproperty
    a_direction_reset: assert property (p_direction_reset) else $error("direction not all inputs");

    property p_alt_reset;
        @(posedge clk)
        rst |=> cfg.alt_enable == ALT_EN_RESET[WIDTH-1:0];
    endproperty
    a_alt_reset: assert property (p_alt_reset) else $error("alt enable reset value wrong");

    property p_selector_write;
        @(posedge clk) disable iff (rst)
        data_end && write_q && mapped_q && idx_q == gpio_cfg_pkg::IDX_SELECTOR |=> sel_q == $past(hwdata[7:0]);
    endproperty
    a_selector_write: assert property (p_selector_write) else $error("selector write lost");

    property p_null_window;
        @(posedge clk) disable iff (rst)
        s_win_write and !sel_ok |=> $stable(sub_q[1]) && $stable(sub_q[2]) && $stable(sub_q[7]) && $stable(sub_q[8]);
    endproperty
    a_null_window: assert property (p_null_window) else $error("window write with no selection changed config");

    property p_window_write;
        @(posedge clk) disable iff (rst)
        s_win_write and sel_ok |=> win_view == $past(hwdata[WIDTH-1:0]) && $stable(sel_q);
    endproperty
    a_window_write: assert property (p_window_write) else $error("window write missed selected register");

    property p_direction_only;
        @(posedge clk) disable iff (rst)
        s_win_write and sel_q == gpio_cfg_pkg::SEL_DIRECTION |=> $stable(cfg.alt_enable) && $stable(cfg.alt_one);
    endproperty
    a_direction_only: assert property (p_direction_only) else $error("direction write touched another register");

    property p_window_read;
        @(posedge clk) disable iff (rst)
        s_win_read |=> hrdata[WIDTH-1:0] == $past(win_view) && hreadyout;
    endproperty
    a_window_read: assert property (p_window_read) else $error("window read returned wrong value");

    // Configuration moves only on a write completed at this port, so other ports cannot disturb it
    property p_config_own_writes;
        @(posedge clk) disable iff (rst)
        !(data_end && write_q) |=> $stable(sel_q) && $stable(cfg.direction) && $stable(cfg.alt_enable);
    endproperty
    a_config_own_writes: assert property (p_config_own_writes) else $error("configuration moved without a write");

    property p_null_read;
        @(posedge clk) disable iff (rst)
        s_win_read and !sel_ok |=> hrdata[WIDTH-1:0] == '0;
    endproperty
    a_null_read: assert property (p_null_read) else $error("window read with no selection not zero");

    property p_alt_enable_write;
        @(posedge clk) disable iff (rst)
        s_win_write and sel_q == gpio_cfg_pkg::SEL_ALT_ENABLE |=>
            cfg.alt_enable == $past(hwdata[WIDTH-1:0]) && $stable(cfg.direction);
    endproperty
    a_alt_enable_write: assert property (p_alt_enable_write) else $error("alt enable write misrouted");

    property p_output_write;
        @(posedge clk) disable iff (rst)
        wr_out |=> cfg.out_value == $past(hwdata[WIDTH-1:0]);
    endproperty
    a_output_write: assert property (p_output_write) else $error("output data write lost");

    // With the enable low the bus must neither finish nor start a transfer
    property p_frozen;
        @(posedge clk) disable iff (rst)
        !ce |=> $stable(st_q) && $stable(hreadyout) && $stable(hrdata);
    endproperty
    a_frozen: assert property (p_frozen) else $error("bus state moved with enable low");

endmodule

// ==== logic/gpio_cfg_pkg.sv ====
/*
 Constants shared by the indirect GPIO port configuration block:
 register indices, selector codes, reset values and pin counts.
 Assumes nothing of its surroundings; every user names items as gpio_cfg_pkg::name.
*/
package gpio_cfg_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_SELECTOR = 12'hFD0;
    localparam logic [11:0] IDX_INPUT = 12'hFD2;
    localparam logic [11:0] IDX_OUTPUT = 12'hFD3;
    localparam logic [11:0] IDX_WINDOW = 12'hFD5;

    // Selector codes
    localparam logic [7:0] SEL_NONE = 8'h00;
    localparam logic [7:0] SEL_DIRECTION = 8'h01;
    localparam logic [7:0] SEL_ALT_ENABLE = 8'h02;
    localparam logic [7:0] SEL_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] SEL_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] SEL_STOP_WAKE = 8'h05;
    localparam logic [7:0] SEL_PULLUP = 8'h06;
    localparam logic [7:0] SEL_ALT_ONE = 8'h07;
    localparam logic [7:0] SEL_ALT_TWO = 8'h08;
    localparam int SUBREG_COUNT = 8;

    // Reset values
    localparam logic [7:0] SELECTOR_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] ALT_EN_RESET_ABC = 8'h00;
    localparam logic [7:0] ALT_EN_RESET_D = 8'h01;
    localparam logic [7:0] SUBREG_RESET = 8'h00;
    localparam logic [7:0] OUTPUT_RESET = 8'h00;

    // Pins per port and alternates per pin
    localparam int PORT_WIDTH = 8;
    localparam int ALT_COUNT = 4;

    // Bus transfer state, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_t;

endpackage

// ==== logic/pin_ctl_if.sv ====
/*
 Bundle of per-pin configuration passed from the register side to the pin driver.
 Assumes one driver (modport ctl) and one user (modport pins) in the same clock domain.
*/
`timescale 1ns/1ns
interface pin_ctl_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] direction;
    logic [WIDTH-1:0] alt_enable;
    logic [WIDTH-1:0] alt_one;
    logic [WIDTH-1:0] alt_two;
    logic [WIDTH-1:0] out_value;
    logic [WIDTH-1:0] open_drain;

    modport ctl (output direction, alt_enable, alt_one, alt_two, out_value, open_drain);
    modport pins (input direction, alt_enable, alt_one, alt_two, out_value, open_drain);
endinterface

// ==== logic/pin_driver.sv ====
/*
 Per-pin output multiplexer, driver enable and input sampling for one port.
 Assumes configuration arrives over pin_ctl_if from registers in the same clock domain.
*/
`timescale 1ns/1ns
module pin_driver #(
    parameter int WIDTH = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Configuration
    pin_ctl_if.pins cfg,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    // Alternate function candidates
    input wire logic [gpio_cfg_pkg::ALT_COUNT-1:0][WIDTH-1:0] alt_out,
    input wire logic [gpio_cfg_pkg::ALT_COUNT-1:0][WIDTH-1:0] alt_oe,
    // Sampled pin levels
    output logic [WIDTH-1:0] in_value
);

    logic [WIDTH-1:0] alt_pick;
    logic [WIDTH-1:0] alt_pick_oe;

    for (genvar g = 0; g < WIDTH; g++) begin : g_pin
        logic [1:0] choice;
        logic drv;
        logic en;
        // Set two supplies the high bit of the alternate choice
        assign choice = {cfg.alt_two[g], cfg.alt_one[g]};
        assign alt_pick[g] = alt_out[choice][g];
        assign alt_pick_oe[g] = alt_oe[choice][g];
        // Alternate enable overrides the direction bit entirely
        assign drv = cfg.alt_enable[g] ? alt_pick[g] : cfg.out_value[g];
        assign en = cfg.alt_enable[g] ? alt_pick_oe[g] : !cfg.direction[g];
        // Open drain releases the pin for a one, so a high comes only from the pull-up
        always_ff @(posedge clk) begin
            if (rst) begin
                pin_out[g] <= 1'b0;
                pin_oe[g] <= 1'b0;
            end else if (ce) begin
                pin_out[g] <= drv;
                pin_oe[g] <= en & !(cfg.open_drain[g] & drv);
            end
        end
    end

    // Pins are sampled every cycle that ce is high; for input pins this is the input value
    always_ff @(posedge clk) begin
        if (rst) begin
            in_value <= '0;
        end else if (ce) begin
            in_value <= pin_in;
        end
    end

    property p_output_drives;
        @(posedge clk) disable iff (rst)
        ce |=> ((pin_out ^ $past(cfg.out_value)) & ~$past(cfg.alt_enable) & ~$past(cfg.direction)) == '0;
    endproperty
    a_output_drives: assert property (p_output_drives) else $error("output pin not driving its data bit");

    property p_input_released;
        @(posedge clk) disable iff (rst)
        ce |=> (pin_oe & ~$past(cfg.alt_enable) & $past(cfg.direction)) == '0;
    endproperty
    a_input_released: assert property (p_input_released) else $error("input pin still driven");

    property p_alt_governs;
        @(posedge clk) disable iff (rst)
        ce |=> ((pin_out ^ $past(alt_pick)) & $past(cfg.alt_enable)) == '0;
    endproperty
    a_alt_governs: assert property (p_alt_governs) else $error("alternate function not on pin");

    property p_input_sampled;
        @(posedge clk) disable iff (rst)
        ce |=> in_value == $past(pin_in);
    endproperty
    a_input_sampled: assert property (p_input_sampled) else $error("pin level not sampled");

endmodule

// ==== tb/pin_pad_model.sv ====
/*
 Behavioural pad and board model for one GPIO port: resolves each pin from the
 device drive, an external board driver and the weak pull-up.
 Assumes the device changes pin_out/pin_oe on clk and the bench sets the board levels.
*/
`timescale 1ns/1ns
module pin_pad_model #(
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pullup_en,
    // Board side
    input wire logic [WIDTH-1:0] ext_level,
    input wire logic [WIDTH-1:0] ext_en,
    // Resolved pin levels
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] float_q = '0;

    // A floating pad toggles, so a stale level is never mistaken for a real one
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end

    // Device drive wins over the board, the board over the pull-up
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_level[i];
            else if (pullup_en[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_q[i];
        end
    end
endmodule

// ==== tb/tb_gpio_port_indirect_config.sv ====
/*
 Self-checking bench for the indirect GPIO port configuration block, with a second
 instance reset as port D to show that ports keep separate state.
 Assumes pin_pad_model as the board and gpio_cfg_pkg for indices and reset values.
*/
`timescale 1ns/1ns
module tb_gpio_port_indirect_config;
    typedef struct packed {
        logic [7:0] sel;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_t;
    localparam logic [31:0] A_SEL = {18'h0, gpio_cfg_pkg::IDX_SELECTOR, 2'b00};
    localparam logic [31:0] A_WIN = {18'h0, gpio_cfg_pkg::IDX_WINDOW, 2'b00};
    localparam logic [31:0] A_IN = {18'h0, gpio_cfg_pkg::IDX_INPUT, 2'b00};
    localparam logic [31:0] A_OUT = {18'h0, gpio_cfg_pkg::IDX_OUTPUT, 2'b00};
    logic clk, rst, ce, hsel_a, hsel_d, hwrite, port_d, hready_a, hready_d, hresp_a;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata_a, hrdata_d, r;
    logic [7:0] pin_out_a, pin_oe_a, pin_level, pullup_a, open_drain_a, high_drive_a, wake_a, piv_a;
    logic [7:0] ext, ext_en, dir_s, alt_en_s, od_s, pu_s, s1_s, s2_s, out_s, lvl_s, held;
    logic [3:0][7:0] alt_out, alt_oe;
    row_t rows [14];
    int n_fail = 0;
    int samples_checked = 0;
    wire hready = hready_a & hready_d;

    gpio_port_indirect_config gpio_port_indirect_config_inst (
        .clk(clk), .rst(rst), .ce(ce), .hsel(hsel_a), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata_a), .hreadyout(hready_a),
        .hresp(hresp_a), .pin_in(pin_level), .pin_out(pin_out_a), .pin_oe(pin_oe_a), .alt_out(alt_out),
        .alt_oe(alt_oe), .open_drain(open_drain_a), .high_drive(high_drive_a), .stop_wake_en(wake_a),
        .pullup_en(pullup_a), .port_input_value(piv_a));
    // Second port instance reset as port D; only its bus side is observed
    gpio_port_indirect_config #(.ALT_EN_RESET(gpio_cfg_pkg::ALT_EN_RESET_D)) gpio_port_indirect_config_d_inst (
        .clk(clk), .rst(rst), .ce(ce), .hsel(hsel_d), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata_d), .hreadyout(hready_d),
        .hresp(), .pin_in(pin_level), .pin_out(), .pin_oe(), .alt_out(alt_out), .alt_oe(alt_oe),
        .open_drain(), .high_drive(), .stop_wake_en(), .pullup_en(), .port_input_value());
    pin_pad_model pin_pad_model_inst (.clk(clk), .pin_out(pin_out_a), .pin_oe(pin_oe_a),
        .pullup_en(pullup_a), .ext_level(ext), .ext_en(ext_en), .pin_level(pin_level));

    // Clock, 8 ns period
    always #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Wait for hready sampled high at a rising edge; only the watchdog ends a hung wait
    task automatic wait_ready();
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
    endtask

    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
        @(posedge clk);
        hsel_a <= ~port_d;
        hsel_d <= port_d;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wdata;
        wait_ready();
        r = port_d ? hrdata_d : hrdata_a;
    endtask

    task automatic rd(input logic [31:0] addr, input logic [7:0] exp);
        bus(addr, 1'b0, 32'h0);
        check(r, {24'h0, exp});
        check({31'h0, hresp_a}, 32'h0);
    endtask

    function automatic void shadow(input logic [7:0] sel, input logic [7:0] d);
        case (sel)
            8'h01: dir_s = d;
            8'h02: alt_en_s = d;
            8'h03: od_s = d;
            8'h06: pu_s = d;
            8'h07: s1_s = d;
            8'h08: s2_s = d;
            default: ;
        endcase
    endfunction

    task automatic cfg(input logic [7:0] sel, input logic [7:0] d);
        bus(A_SEL, 1'b1, {24'h0, sel});
        bus(A_WIN, 1'b1, {24'h0, d});
        shadow(sel, d);
    endtask

    // Expected {oe, driven value} per pin from the shadow configuration
    function automatic logic [15:0] pins_exp();
        logic [7:0] oe;
        logic [7:0] ov;
        int k;
        for (int i = 0; i < 8; i++) begin
            k = {s2_s[i], s1_s[i]};
            oe[i] = alt_en_s[i] ? alt_oe[k][i] : ~dir_s[i];
            ov[i] = alt_en_s[i] ? alt_out[k][i] : out_s[i];
            if (od_s[i] && ov[i])
                oe[i] = 1'b0;
        end
        return {oe, ov & oe};
    endfunction

    // Pins follow one cycle after the last change; floating pins without pull-up are masked
    task automatic check_pins();
        logic [15:0] e;
        logic [7:0] known;
        repeat (2) @(posedge clk);
        #1;
        e = pins_exp();
        known = e[15:8] | ext_en | pu_s;
        lvl_s = (e[7:0] | (~e[15:8] & ext_en & ext) | (~e[15:8] & ~ext_en & pu_s)) & known;
        check({24'h0, pin_oe_a}, {24'h0, e[15:8]});
        check({24'h0, pin_out_a & pin_oe_a}, {24'h0, e[7:0]});
        check({24'h0, piv_a & known}, {24'h0, lvl_s});
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        {dir_s, alt_en_s, od_s, pu_s, s1_s, s2_s, out_s} = {8'hFF, 48'h0};
    endtask

    task automatic reset_values();
        rd(A_SEL, 8'h00);
        rd(A_OUT, 8'h00);
        bus(A_SEL, 1'b1, 32'h1);
        rd(A_WIN, 8'hFF);
        bus(A_SEL, 1'b1, 32'h2);
        rd(A_WIN, 8'h00);
        check_pins();
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        {clk, rst, ce, hsel_a, hsel_d, hwrite, port_d, htrans, haddr, hwdata} = {4'b0110, 69'h0};
        hsize = 3'h2;
        alt_out = {8'hF0, 8'hCC, 8'hAA, 8'h55}; // Every pin has four alternates, so any enable is legal
        alt_oe = {8'h0F, 8'h3C, 8'hFF, 8'h96};
        ext = 8'h6B;
        ext_en = 8'hFF;
        rows = '{'{8'h01, 1'b1, 8'h5A, 8'h5A}, '{8'h02, 1'b1, 8'h3C, 8'h3C}, '{8'h03, 1'b1, 8'hA5, 8'hA5},
            '{8'h04, 1'b1, 8'h96, 8'h96}, '{8'h05, 1'b1, 8'h69, 8'h69}, '{8'h06, 1'b1, 8'hC3, 8'hC3},
            '{8'h07, 1'b1, 8'h0F, 8'h0F}, '{8'h08, 1'b1, 8'h33, 8'h33}, '{8'h00, 1'b1, 8'hFF, 8'h00},
            '{8'h09, 1'b1, 8'hFF, 8'h00}, '{8'hFF, 1'b1, 8'hFF, 8'h00}, '{8'h01, 1'b0, 8'h00, 8'h5A},
            '{8'h07, 1'b0, 8'h00, 8'h0F}, '{8'h08, 1'b0, 8'h00, 8'h33}};
        do_reset();
        reset_values();
        $display("test reset values done");
        for (int i = 0; i < 14; i++) begin
            bus(A_SEL, 1'b1, {24'h0, rows[i].sel});
            rd(A_SEL, rows[i].sel);
            if (rows[i].wr) begin
                bus(A_WIN, 1'b1, {24'h0, rows[i].wdata});
                shadow(rows[i].sel, rows[i].wdata);
            end
            rd(A_WIN, rows[i].exp);
        end
        check({open_drain_a, high_drive_a, wake_a, pullup_a}, {8'hA5, 8'h96, 8'h69, 8'hC3});
        check_pins();
        $display("test selector table done");
        cfg(8'h01, 8'hF0);
        bus(A_OUT, 1'b1, 32'hA5);
        out_s = 8'hA5;
        rd(A_OUT, 8'hA5);
        check_pins();
        rd(A_IN, lvl_s);
        cfg(8'h02, 8'h00);
        cfg(8'h03, 8'h00);
        check_pins();
        ext_en <= 8'h00;
        check_pins();
        ext_en <= 8'hFF;
        $display("test direction and alternate done");
        @(posedge clk);
        ce <= 1'b0;
        ext <= 8'h94;
        #1;
        held = piv_a;
        repeat (4) @(posedge clk);
        #1;
        check({24'h0, piv_a}, {24'h0, held});
        @(posedge clk);
        ce <= 1'b1;
        check_pins();
        $display("test clock enable done");
        port_d = 1'b1;
        rd(A_SEL, 8'h00);
        bus(A_SEL, 1'b1, 32'h2);
        rd(A_WIN, 8'h01);
        bus(A_SEL, 1'b1, 32'h1);
        bus(A_WIN, 1'b1, 32'h00);
        port_d = 1'b0;
        rd(A_SEL, 8'h03);
        check_pins();
        $display("test port independence done");
        bus(32'h3F44, 1'b1, 32'hFF);
        rd(32'h3F44, 8'h00);
        rd(A_SEL, 8'h03);
        $display("test unmapped address done");
        cfg(8'h06, 8'hFF);
        do_reset();
        reset_values();
        $display("test second reset done");
        results();
    end
endmodule
